// [inc/vic_params.svh]
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH
// Register offsets
`define VIC_OFS_CONFIG 8'h00
`define VIC_OFS_CAPTURE 8'h04
`define VIC_OFS_STATUS 8'h08
`define VIC_OFS_CUR_LINE 8'h10
`define VIC_OFS_LINE_TARGET 8'h14
`define VIC_OFS_VID_ODD_BASE 8'h20
`define VIC_OFS_VID_EVEN_BASE 8'h24
`define VIC_OFS_VBI_ODD_BASE 8'h40
`define VIC_OFS_VBI_EVEN_BASE 8'h44
// Configuration fields
`define VIC_CFG_THRESH 22
`define VIC_CFG_STORE_B 21
`define VIC_CFG_STORE_A 20
`define VIC_CFG_STORE_ANC 19
`define VIC_CFG_OVERRIDE 18
`define VIC_CFG_TASK_SEL 17
`define VIC_CFG_VBI_MODE 16
`define VIC_CFG_MASK 32'h007F0003
// Capture control fields
`define VIC_CAP_LINE_IE 17
`define VIC_CAP_FIELD_IE 16
`define VIC_CAP_AUTO_FLIP 10
`define VIC_CAP_VBI_EN 9
`define VIC_CAP_VID_EN 8
`define VIC_CAP_MASK 32'h00030703
// Status fields
`define VIC_ST_FIELD 24
`define VIC_ST_NOT_UPD 21
`define VIC_ST_OVF 20
`define VIC_ST_LINE_PEND 17
`define VIC_ST_FIELD_PEND 16
`define VIC_ST_VID_ACTIVE 8
`define VIC_ST_RUN 0
// Reset values and sizes
`define VIC_RESET_WORD 32'h00000000
`define VIC_BASE_MASK 32'hFFFFFFF0
`define VIC_FIFO_DEPTH 16
`define VIC_THRESH_LO 8'h40
`define VIC_THRESH_HI 8'h20
`endif

// [inc/vic_pkg.sv]
package vic_pkg;
   // Class of a received data word
   typedef enum logic [1:0] {KIND_VIDEO, KIND_ANC, KIND_TASK_A, KIND_TASK_B} vic_kind_t;
   // Capture run state
   typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_ACTIVE} vic_run_t;
endpackage : vic_pkg

// [inc/vic_link_if.sv]
interface vic_link_if;
   import vic_pkg::*;
   logic [31:0] linkWord;
   vic_kind_t linkKind;
   logic wordTog;
   logic lineTog;
   logic fieldTog;
   logic fieldOdd;
   // Word, kind and field parity are held stable across each toggle
   modport rx (output linkWord, linkKind, wordTog, lineTog, fieldTog, fieldOdd);
   modport core (input linkWord, linkKind, wordTog, lineTog, fieldTog, fieldOdd);
endinterface : vic_link_if

// [design/vic_link_rx.sv]
`include "vic_params.svh"
module vic_link_rx
   import vic_pkg::*;
(
   input wire logic pclk,
   input wire logic rst_n,
   input wire logic [7:0] pixData,
   input wire logic videoHorizontalRef,
   input wire logic videoVerticalSyncIn,
   vic_link_if.rx link
);
   logic [9:0] pinS1, pinS2;
   logic [23:0] hist;
   logic inActive, ancAct, vbiReg, taskA, vPrev, vsPrev, codesSeen;
   logic [1:0] byteCnt;
   logic [31:0] packWord;
   ////////////////////////////////////////////////////////////////////////
   // Decode of timing reference and ancillary preambles
   wire [7:0] curByte = pinS2[7:0];
   wire isCode = (hist == 24'hFF0000);
   wire isAdf = (hist == 24'h00FFFF);
   wire vsRise = pinS2[9] && !vsPrev && !codesSeen;
   wire codeField = isCode && curByte[5] && !vPrev;
   wire byteOk = (inActive || ancAct) && !isCode && (curByte != 8'hFF) && (curByte != 8'h00);
   wire vic_kind_t byteKind = ancAct ? KIND_ANC : (vbiReg ? (taskA ? KIND_TASK_A : KIND_TASK_B) : KIND_VIDEO);
   ////////////////////////////////////////////////////////////////////////
   // Pins pass two stages before use
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         pinS1 <= 10'h000;
         pinS2 <= 10'h000;
         hist <= 24'h000000;
         vsPrev <= 1'b0;
      end else begin
         pinS1 <= {videoVerticalSyncIn, videoHorizontalRef, pixData};
         pinS2 <= pinS1;
         hist <= {hist[15:0], curByte};
         vsPrev <= pinS2[9];
      end
   end
   // Stream state; pins give field parity only when no codes arrive
   always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         {inActive, ancAct, vbiReg, taskA, vPrev, codesSeen} <= 6'h00;
         {link.lineTog, link.fieldTog, link.fieldOdd, link.wordTog} <= 4'h0;
         byteCnt <= 2'h0;
         packWord <= 32'h00000000;
         link.linkWord <= 32'h00000000;
         link.linkKind <= KIND_VIDEO;
      end else begin
         if (isCode) begin
            codesSeen <= 1'b1;
            ancAct <= 1'b0;
            inActive <= !curByte[4];
            vbiReg <= curByte[5];
            taskA <= curByte[7];
            vPrev <= curByte[5];
            byteCnt <= 2'h0;
            link.lineTog <= link.lineTog ^ curByte[4];
         end else if (isAdf) begin
            ancAct <= 1'b1;
            byteCnt <= 2'h0;
         end
         if (codeField || vsRise) begin
            link.fieldTog <= !link.fieldTog;
            link.fieldOdd <= codeField ? !curByte[6] : !pinS2[8];
         end
         // Four bytes form a word; the word then holds for at least four clocks
         if (byteOk && !isAdf) begin
            packWord <= {curByte, packWord[31:8]};
            byteCnt <= byteCnt + 2'h1;
            if (byteCnt == 2'h3) begin
               link.linkWord <= {curByte, packWord[31:8]};
               link.linkKind <= byteKind;
               link.wordTog <= !link.wordTog;
            end
         end
      end
   end
endmodule : vic_link_rx

// [design/vic_store_fifo.sv]
`include "vic_params.svh"
module vic_store_fifo
   import vic_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pushValid,
   input wire logic [32:0] pushData,
   input wire logic thresh32,
   input wire logic memGrant,
   output logic memReq,
   output logic [32:0] headData,
   output logic overflow
);
   logic [32:0] mem [`VIC_FIFO_DEPTH];
   logic [4:0] count;
   ////////////////////////////////////////////////////////////////////////
   // Head always sits in slot 0 so the bus sees a flop directly
   wire pop = memGrant && (count != 5'h00);
   wire full = (count == 5'(`VIC_FIFO_DEPTH));
   wire push = pushValid && (!full || pop);
   wire [4:0] slot = count - {4'h0, pop};
   wire [4:0] next_count = count + {4'h0, push} - {4'h0, pop};
   wire [7:0] thresh = thresh32 ? `VIC_THRESH_HI : `VIC_THRESH_LO;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 5'h00;
         memReq <= 1'b0;
         overflow <= 1'b0;
      end else begin
         count <= next_count;
         memReq <= {1'b0, next_count, 2'h0} >= thresh;
         overflow <= pushValid && full && !pop;
      end
   end
   // Shift on pop, write behind the last held word
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `VIC_FIFO_DEPTH; i++) mem[i] <= 33'h000000000;
      end else begin
         for (int i = 0; i < `VIC_FIFO_DEPTH; i++) begin
            if (push && (5'(i) == slot)) mem[i] <= pushData;
            else if (pop && (i < `VIC_FIFO_DEPTH - 1)) mem[i] <= mem[i + 1];
         end
      end
   end
   assign headData = mem[0];
   chk_req_thresh: assert property (@(posedge mclk) disable iff (!rst_n)
      ({1'b0, count, 2'h0} >= thresh) && $stable(count) && $stable(thresh32) && !pop |=> memReq)
      else $error("bus request missing above threshold");
endmodule : vic_store_fifo

// [design/vic_capture_top.sv]
`include "vic_params.svh"
// Operation
// - FIFO requests the bus at 64 bytes, or 32 when threshold bit set.
// - Override on and task B store bit set stores raw task B VBI.
// - Override on and task A store bit set stores raw task A VBI.
// - Override on and ancillary store bit set stores raw ancillary VBI.
// - With override on, the three store bits, not mode or task select, pick the VBI kinds stored.
// - Task select picks task B at 0, task A at 1, in task mode.
// - Without override, mode 0 stores ancillary data, mode 1 stores a task.
// - Line interrupt raised when current line equals the line target.
// - Field interrupt raised at each field end, capture on or not.
// - Auto-flip off: field parity taken from pins or stream codes.
// - Auto-flip on: parity alternates per field, odd buffer first.
// - VBI stored only with VBI enable, video only with video enable.
// - Run field: 00 stop at line end, 01 at field end, 11 start.
// - Status bit shows field in process, 1 odd, 0 even.
// - Status bit set while any written base value awaits taking effect.
// - FIFO overflow sets a sticky flag, cleared by writing one.
// - Line interrupt pending flag, cleared by writing one.
// - Field interrupt pending flag, cleared by writing one.
// - Base writes wait; all apply when next field's first data stores.
// - Current line counter returns to zero at every field start.
module vic_capture_top
   import vic_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pclk,
   input wire logic [7:0] pixData,
   input wire logic videoHorizontalRef,
   input wire logic videoVerticalSyncIn,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [31:0] regWrData,
   output logic [31:0] regRdData,
   input wire logic memGrant,
   output logic memReq,
   output logic [31:0] memData,
   output logic memIsVbi,
   output logic [31:0] memBase,
   output logic captureIrqN
);
   logic [31:0] portConfig, captureCtrl;
   logic [9:0] curLine, lineTarget;
   logic [31:0] actBase [4];
   logic [31:0] pendBase [4];
   logic notUpdated, overflowFlag, linePend, fieldPend, curOdd, firstOfField;
   logic [2:0] togS1, togS2, togS3;
   logic [31:0] wordHold;
   vic_kind_t kindHold;
   logic pushValid, storeNow;
   logic [32:0] headData;
   logic fifoOverflow;
   vic_run_t runState, next_runState;
   vic_link_if link ();

   ////////////////////////////////////////////////////////////////////////
   // Link side receiver on the pixel clock
   vic_link_rx u_rx (
      .pclk(pclk),
      .rst_n(rst_n),
      .pixData(pixData),
      .videoHorizontalRef(videoHorizontalRef),
      .videoVerticalSyncIn(videoVerticalSyncIn),
      .link(link)
   );

   ////////////////////////////////////////////////////////////////////////
   // Picks the base slot for a stored word: video or VBI, odd or even
   function automatic logic [1:0] baseSlot(input logic isVbi, input logic odd);
      baseSlot = {isVbi, !odd};
   endfunction : baseSlot

   // True when a VBI word of this kind is to be kept
   function automatic logic vbiWanted(input logic [31:0] cfg, input vic_kind_t kind);
      logic taskPick;
      taskPick = cfg[`VIC_CFG_TASK_SEL] ? (kind == KIND_TASK_A) : (kind == KIND_TASK_B);
      if (kind == KIND_VIDEO) vbiWanted = 1'b0;
      else if (cfg[`VIC_CFG_OVERRIDE])
         vbiWanted = ((kind == KIND_TASK_B) && cfg[`VIC_CFG_STORE_B])
            || ((kind == KIND_TASK_A) && cfg[`VIC_CFG_STORE_A])
            || ((kind == KIND_ANC) && cfg[`VIC_CFG_STORE_ANC]);
      else if (cfg[`VIC_CFG_VBI_MODE]) vbiWanted = taskPick;
      else vbiWanted = (kind == KIND_ANC);
   endfunction : vbiWanted

   ////////////////////////////////////////////////////////////////////////
   // Toggle crossings from the pixel clock; stages two and three feed logic
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         togS1 <= 3'h0;
         togS2 <= 3'h0;
         togS3 <= 3'h0;
      end else begin
         togS1 <= {link.fieldTog, link.lineTog, link.wordTog};
         togS2 <= togS1;
         togS3 <= togS2;
      end
   end

   wire [2:0] togEvt = togS2 ^ togS3;
   wire wordEvt = togEvt[0];
   wire lineEvt = togEvt[1];
   wire fieldEvt = togEvt[2];

   // Held word is stable for several clocks after its toggle lands
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wordHold <= 32'h00000000;
         kindHold <= KIND_VIDEO;
         pushValid <= 1'b0;
      end else begin
         wordHold <= link.linkWord;
         kindHold <= link.linkKind;
         pushValid <= wordEvt && storeNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register decode and field views
   wire [1:0] runMode = captureCtrl[1:0];
   wire autoFlip = captureCtrl[`VIC_CAP_AUTO_FLIP];
   wire lineIntEn = captureCtrl[`VIC_CAP_LINE_IE];
   wire fieldIntEn = captureCtrl[`VIC_CAP_FIELD_IE];
   wire vidCapEn = captureCtrl[`VIC_CAP_VID_EN];
   wire vbiCapEn = captureCtrl[`VIC_CAP_VBI_EN];
   wire running = (runState == RUN_ACTIVE);
   wire isVbiWord = (link.linkKind != KIND_VIDEO);
   wire storeVid = !isVbiWord && vidCapEn;
   wire storeVbi = vbiWanted(portConfig, link.linkKind) && vbiCapEn;
   assign storeNow = running && (storeVid || storeVbi);
   wire wrCfg = regWrEn && (regAddr == `VIC_OFS_CONFIG);
   wire wrCap = regWrEn && (regAddr == `VIC_OFS_CAPTURE);
   wire wrStat = regWrEn && (regAddr == `VIC_OFS_STATUS);
   wire wrTgt = regWrEn && (regAddr == `VIC_OFS_LINE_TARGET);
   wire [3:0] wrBase = {regWrEn && (regAddr == `VIC_OFS_VBI_EVEN_BASE),
      regWrEn && (regAddr == `VIC_OFS_VBI_ODD_BASE),
      regWrEn && (regAddr == `VIC_OFS_VID_EVEN_BASE),
      regWrEn && (regAddr == `VIC_OFS_VID_ODD_BASE)};
   wire commit = pushValid && firstOfField;
   wire lineHit = lineEvt && lineIntEn && (curLine == lineTarget);
   wire fieldHit = fieldEvt && fieldIntEn;
   wire [31:0] statusWord = {7'h00, curOdd, 2'h0, notUpdated, overflowFlag, 2'h0, linePend, fieldPend,
      7'h00, running && vidCapEn, 7'h00, runState != RUN_IDLE};

   ////////////////////////////////////////////////////////////////////////
   // Read selection; unmapped offsets read zero
   wire [31:0] rdMux =
      (regAddr == `VIC_OFS_CONFIG) ? portConfig :
      (regAddr == `VIC_OFS_CAPTURE) ? captureCtrl :
      (regAddr == `VIC_OFS_STATUS) ? statusWord :
      (regAddr == `VIC_OFS_CUR_LINE) ? {22'h000000, curLine} :
      (regAddr == `VIC_OFS_LINE_TARGET) ? {22'h000000, lineTarget} :
      (regAddr == `VIC_OFS_VID_ODD_BASE) ? actBase[0] :
      (regAddr == `VIC_OFS_VID_EVEN_BASE) ? actBase[1] :
      (regAddr == `VIC_OFS_VBI_ODD_BASE) ? actBase[2] :
      (regAddr == `VIC_OFS_VBI_EVEN_BASE) ? actBase[3] : `VIC_RESET_WORD;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) regRdData <= `VIC_RESET_WORD;
      else if (regRdEn) regRdData <= rdMux;
   end

   // Writable control registers; reserved bits are not stored
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         portConfig <= `VIC_RESET_WORD;
         captureCtrl <= `VIC_RESET_WORD;
         lineTarget <= 10'h000;
      end else begin
         if (wrCfg) portConfig <= regWrData & `VIC_CFG_MASK;
         if (wrCap) captureCtrl <= regWrData & `VIC_CAP_MASK;
         if (wrTgt) lineTarget <= regWrData[9:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture run control
   always_comb begin
      next_runState = runState;
      case (runState)
         RUN_IDLE: begin
            if (runMode == 2'h3) next_runState = RUN_WAIT;
         end
         RUN_WAIT: begin
            if (runMode != 2'h3) next_runState = RUN_IDLE;
            else if (fieldEvt) next_runState = RUN_ACTIVE;
         end
         RUN_ACTIVE: begin
            if ((runMode == 2'h0) && lineEvt) next_runState = RUN_IDLE;
            else if ((runMode == 2'h1) && fieldEvt) next_runState = RUN_IDLE;
         end
         default: next_runState = RUN_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) runState <= RUN_IDLE;
      else runState <= next_runState;
   end

   ////////////////////////////////////////////////////////////////////////
   // Field parity: detected, or alternated from odd when auto-flip is on
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) curOdd <= 1'b0;
      else if (fieldEvt && !autoFlip) curOdd <= link.fieldOdd;
      else if (fieldEvt && (runState == RUN_WAIT)) curOdd <= 1'b1;
      else if (fieldEvt) curOdd <= !curOdd;
   end

   // Line count restarts each field
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) curLine <= 10'h000;
      else if (fieldEvt) curLine <= 10'h000;
      else if (lineEvt) curLine <= curLine + 10'h001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky flags: a new event beats a clear in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         overflowFlag <= 1'b0;
         linePend <= 1'b0;
         fieldPend <= 1'b0;
      end else begin
         overflowFlag <= fifoOverflow || (overflowFlag && !(wrStat && regWrData[`VIC_ST_OVF]));
         linePend <= lineHit || (linePend && !(wrStat && regWrData[`VIC_ST_LINE_PEND]));
         fieldPend <= fieldHit || (fieldPend && !(wrStat && regWrData[`VIC_ST_FIELD_PEND]));
      end
   end

   // Interrupt line low while an enabled flag is pending
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) captureIrqN <= 1'b1;
      else captureIrqN <= !((linePend && lineIntEn) || (fieldPend && fieldIntEn));
   end

   ////////////////////////////////////////////////////////////////////////
   // Double-buffered base addresses; a write in the commit cycle stays pending
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            actBase[i] <= `VIC_RESET_WORD;
            pendBase[i] <= `VIC_RESET_WORD;
         end
         notUpdated <= 1'b0;
         firstOfField <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wrBase[i]) pendBase[i] <= regWrData & `VIC_BASE_MASK;
            if (commit) actBase[i] <= pendBase[i];
         end
         notUpdated <= (|wrBase) || (notUpdated && !commit);
         if (fieldEvt) firstOfField <= 1'b1;
         else if (pushValid) firstOfField <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port FIFO toward the memory bus
   vic_store_fifo u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .pushValid(pushValid),
      .pushData({kindHold != KIND_VIDEO, wordHold}),
      .thresh32(portConfig[`VIC_CFG_THRESH]),
      .memGrant(memGrant),
      .memReq(memReq),
      .headData(headData),
      .overflow(fifoOverflow)
   );

   assign memData = headData[31:0];
   assign memIsVbi = headData[32];

   // Base for the word at the head, by class and current field
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) memBase <= `VIC_RESET_WORD;
      else memBase <= actBase[baseSlot(headData[32], curOdd)];
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   chk_line_irq_set: assert property (@(posedge mclk) disable iff (!rst_n)
      lineHit |=> linePend ##1 !captureIrqN)
      else $error("line match did not raise interrupt");
   chk_field_irq_set: assert property (@(posedge mclk) disable iff (!rst_n)
      fieldHit && !(wrCap && !regWrData[`VIC_CAP_FIELD_IE]) |=> fieldPend ##1 !captureIrqN)
      else $error("field end did not raise interrupt");
   chk_irq_release: assert property (@(posedge mclk) disable iff (!rst_n)
      !(linePend && lineIntEn) && !(fieldPend && fieldIntEn) |=> captureIrqN)
      else $error("interrupt held without enabled pending flag");
   chk_zero_write_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStat && !regWrData[`VIC_ST_LINE_PEND] && linePend |=> linePend)
      else $error("line pending cleared by zero write");
   chk_ovf_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      fifoOverflow |=> overflowFlag)
      else $error("overflow not recorded");
   chk_base_commit: assert property (@(posedge mclk) disable iff (!rst_n)
      commit && !(|wrBase) |=> !notUpdated && (actBase[0] == $past(pendBase[0])))
      else $error("pending base not applied");
   chk_line_restart: assert property (@(posedge mclk) disable iff (!rst_n)
      fieldEvt |=> (curLine == 10'h000))
      else $error("line count not restarted");
   chk_vbi_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      wordEvt && isVbiWord && !vbiCapEn |=> !pushValid)
      else $error("VBI stored while disabled");
   chk_override_anc: assert property (@(posedge mclk) disable iff (!rst_n)
      wordEvt && portConfig[`VIC_CFG_OVERRIDE] && (link.linkKind == KIND_ANC)
      && !portConfig[`VIC_CFG_STORE_ANC] |=> !pushValid)
      else $error("ancillary stored against override");
   chk_stop_line: assert property (@(posedge mclk) disable iff (!rst_n)
      running && (runMode == 2'h0) && lineEvt |=> (runState == RUN_IDLE))
      else $error("capture did not stop at line end");
   chk_flip_odd_first: assert property (@(posedge mclk) disable iff (!rst_n)
      (runState == RUN_WAIT) && fieldEvt && autoFlip |=> curOdd && running)
      else $error("auto-flip did not start on odd");
   chk_notupd_set: assert property (@(posedge mclk) disable iff (!rst_n)
      (|wrBase) |=> notUpdated)
      else $error("base write not flagged");
   chk_line_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStat && regWrData[`VIC_ST_LINE_PEND] && !lineHit |=> !linePend)
      else $error("line pending not cleared");
   chk_field_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStat && regWrData[`VIC_ST_FIELD_PEND] && !fieldHit |=> !fieldPend)
      else $error("field pending not cleared");
   chk_ovf_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      wrStat && regWrData[`VIC_ST_OVF] && !fifoOverflow |=> !overflowFlag)
      else $error("overflow flag not cleared");
   chk_start_field: assert property (@(posedge mclk) disable iff (!rst_n)
      (runState == RUN_WAIT) && (runMode == 2'h3) && fieldEvt |=> running)
      else $error("capture did not start at field");
   chk_field_parity: assert property (@(posedge mclk) disable iff (!rst_n)
      fieldEvt && !autoFlip |=> (curOdd == $past(link.fieldOdd)))
      else $error("field parity not taken from stream");
   chk_line_count: assert property (@(posedge mclk) disable iff (!rst_n)
      lineEvt && !fieldEvt |=> (curLine == $past(curLine) + 10'h001))
      else $error("line count did not advance");
endmodule : vic_capture_top

// [testbench/vic_video_source.sv]
module vic_video_source (
   input wire logic pclk,
   output logic [7:0] pixData,
   output logic videoHorizontalRef,
   output logic videoVerticalSyncIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins stay low: timing comes from the stream codes only
   initial begin
      pixData = 8'h10;
      videoHorizontalRef = 1'b0;
      videoVerticalSyncIn = 1'b0;
   end
   // One byte per link clock, launched on its rising edge
   task automatic putByte(input logic [7:0] b);
      @(posedge pclk);
      pixData <= b;
   endtask : putByte
   // Timing code; the flag byte is held afterwards as blanking
   task automatic code(input logic [7:0] xy);
      putByte(8'hFF);
      putByte(8'h00);
      putByte(8'h00);
      putByte(xy);
   endtask : code
   // Word goes out low byte first
   task automatic putWord(input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         putByte(w[8*i+:8]);
      end
   endtask : putWord
endmodule : vic_video_source

// [testbench/tb.sv]
`include "vic_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, pclk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, memGrant = 0, rdSeen = 0;
   logic [7:0] regAddr = 8'h00, pixData;
   logic [31:0] regWrData = 32'h0, regRdData, memData, memBase, expBase = 32'h0, w, m;
   logic memReq, memIsVbi, captureIrqN, hRef, vSync;
   logic [31:0] expQ[$], mskQ[$], vidQ[$];
   int err_total = 0, samples_checked = 0, cycles = 0, seed = 49;
   ////////////////////////////////////////
   // Core clock free; link clock offset so the two never line up
   initial forever #2 mclk = ~mclk;
   initial begin
      #1.3;
      forever #6 pclk = ~pclk;
   end
   vic_capture_top u_vic_capture_top (.mclk(mclk), .rst_n(rst_n), .pclk(pclk), .pixData(pixData),
      .videoHorizontalRef(hRef), .videoVerticalSyncIn(vSync), .regAddr(regAddr), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .memGrant(memGrant),
      .memReq(memReq), .memData(memData), .memIsVbi(memIsVbi), .memBase(memBase), .captureIrqN(captureIrqN));
   vic_video_source u_vic_video_source (.pclk(pclk), .pixData(pixData), .videoHorizontalRef(hRef),
      .videoVerticalSyncIn(vSync));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   // Read data lands one edge after the strobe; a popped word shows on the grant edge
   always @(posedge mclk) begin
      rdSeen <= regRdEn;
      if (rdSeen) begin
         m = mskQ.pop_front();
         chk(regRdData & m, expQ.pop_front() & m);
      end
      if (memGrant) begin
         chk(memData, vidQ.pop_front());
         chk(memBase, expBase);
      end
   end
   // Hang guard, far above the length of the sequence
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end
   ////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
      expQ.push_back(e);
      mskQ.push_back(msk);
      @(posedge mclk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      @(posedge mclk);
   endtask : rd
   // Field start code, then time for the event to cross
   task automatic fld(input logic [7:0] xy);
      u_vic_video_source.code(xy);
      repeat (12) @(posedge mclk);
   endtask : fld
   // Active line of n random words; bytes avoid the reserved 00 and FF
   task automatic line(input int n);
      u_vic_video_source.code(8'h00);
      repeat (n) begin
         for (int i = 0; i < 4; i++) begin
            w[8*i+:8] = 8'h01 + 8'({$random(seed)} % 254);
         end
         vidQ.push_back(w);
         u_vic_video_source.putWord(w);
      end
      u_vic_video_source.code(8'h10);
      repeat (12) @(posedge mclk);
   endtask : line
   ////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`VIC_OFS_CONFIG, 32'h0, '1);
      rd(`VIC_OFS_CAPTURE, 32'h0, '1);
      rd(8'h0C, 32'h0, '1);
      wr(`VIC_OFS_CONFIG, 32'hFFFFFFFF);
      rd(`VIC_OFS_CONFIG, 32'h007F0003, '1);
      wr(`VIC_OFS_CONFIG, 32'h00400002);
      wr(`VIC_OFS_LINE_TARGET, 32'h2);
      wr(`VIC_OFS_VID_ODD_BASE, 32'h12345678);
      rd(`VIC_OFS_STATUS, 32'h00200000, 32'h00200000);
      rd(`VIC_OFS_VID_ODD_BASE, 32'h0, '1);
      wr(`VIC_OFS_CAPTURE, 32'h00030103);
      fld(8'h20);
      line(3);
      rd(`VIC_OFS_STATUS, 32'h0, 32'h00220000);
      line(3);
      line(1);
      chk(memReq, 32'h0);
      line(1);
      chk(memReq, 32'h1);
      rd(`VIC_OFS_STATUS, 32'h01030101, 32'h01230101);
      rd(`VIC_OFS_CUR_LINE, 32'h4, 32'h3FF);
      rd(`VIC_OFS_VID_ODD_BASE, 32'h12345670, '1);
      chk(captureIrqN, 32'h0);
      expBase = 32'h12345670;
      memGrant <= 1'b1;
      repeat (8) @(posedge mclk);
      memGrant <= 1'b0;
      line(17);
      wr(`VIC_OFS_STATUS, 32'h0);
      rd(`VIC_OFS_STATUS, 32'h00130000, 32'h00130000);
      wr(`VIC_OFS_STATUS, 32'h00130000);
      rd(`VIC_OFS_STATUS, 32'h0, 32'h00130000);
      chk(captureIrqN, 32'h1);
      wr(`VIC_OFS_CAPTURE, 32'h00010100);
      line(0);
      rd(`VIC_OFS_STATUS, 32'h0, 32'h00000101);
      fld(8'h60);
      rd(`VIC_OFS_STATUS, 32'h00010000, 32'h01010000);
      rd(`VIC_OFS_CUR_LINE, 32'h0, 32'h3FF);
      chk(captureIrqN, 32'h0);
      wr(`VIC_OFS_CAPTURE, 32'h00010503);
      line(0);
      fld(8'h60);
      rd(`VIC_OFS_STATUS, 32'h01010101, 32'h01010101);
      summarize();
   end
endmodule : tb
